// ===== src/edid_emu_pkg.sv
// shared constants and types for the display-identification emulator
package edid_emu_pkg;
   localparam int N_IN        = 2;        // video inputs
   localparam int IN_W        = 1;        // input index width
   localparam int BASE_LEN    = 128;      // base structure bytes
   localparam int FULL_LEN    = 256;      // base plus one extension
   localparam int ENTRY_W     = 6;        // library entry index width
   localparam int HPD_TIME_MS = 2000;     // presence toggle time
   localparam int CLK_MHZ     = 100;      // clk_i rate
   localparam int HPD_CYCLES  = HPD_TIME_MS * 1000 * CLK_MHZ;
   localparam int HPD_W       = 28;       // presence counter width
   localparam int N_LANES     = 3;        // differential data lanes
   localparam int SKEW_DEPTH  = 4;        // deskew delay line taps
   localparam logic [7:0] EXT_CNT_ADDR = 8'h7E; // extension count byte
   localparam logic [7:0] BASE_LAST    = 8'h7F; // last base byte
   localparam logic [7:0] FULL_LAST    = 8'hFF; // last extension byte
   localparam logic [23:0] HDMI_TAG    = 24'h030C00; // vendor tag bytes
   localparam logic [7:0] NO_DATA      = 8'hFF; // read past the end
   typedef enum logic [0:0] {C_IDLE, C_COPY} copy_state_t;
   typedef enum logic [0:0] {MODE_STATIC, MODE_DYNAMIC} emu_mode_t;
endpackage

// ===== src/edid_emu_hdcp.sv
// display-identification emulation, presence toggle, protection and deskew
// Functional notes
// - base structure is 128 bytes
// - optional second 128-byte extension block
// - HDMI flag only with extension present
// - structure change drops presence for 2 s
// - sink structure written to non-volatile store
// - dynamic mode follows newly attached sink
// - static mode copies from library entry
// - any entry assignable to any input
// - separate memory per input, independent
// - reprogramming allowed with source connected
// - never encrypt towards non-capable sink
// - alert screen for protected, non-capable
// - disabled input reports not protection-capable
// - auto mode sends unprotected content clear
// - remove intra-lane and inter-lane skew
`timescale 1ns/10ps
module edid_emu_hdcp
   import edid_emu_pkg::*;
#(
   parameter int HPD_CYC = edid_emu_pkg::HPD_CYCLES  // presence low time
) (
   input  wire logic                                   clk_i,
   input  wire logic                                   reset_i,
   input  wire logic                                   cmd_valid_i,
   input  wire logic [edid_emu_pkg::IN_W-1:0]          cmd_input_i,
   input  wire logic                                   cmd_dynamic_i,
   input  wire logic [edid_emu_pkg::ENTRY_W-1:0]       cmd_entry_i,
   output logic                                        cmd_ready_o,
   output logic                                        src_rd_o,
   output logic                                        src_dynamic_o,
   output logic [edid_emu_pkg::ENTRY_W-1:0]            src_entry_o,
   output logic [7:0]                                  src_addr_o,
   input  wire logic [7:0]                             src_data_i,
   input  wire logic                                   sink_wr_i,
   input  wire logic [7:0]                             sink_addr_i,
   input  wire logic [7:0]                             sink_data_i,
   input  wire logic                                   sink_new_i,
   output logic                                        nvm_we_o,
   output logic [7:0]                                  nvm_addr_o,
   output logic [7:0]                                  nvm_data_o,
   input  wire logic [edid_emu_pkg::N_IN-1:0]          ddc_rd_i,
   input  wire logic [edid_emu_pkg::N_IN-1:0][7:0]     ddc_addr_i,
   output logic [edid_emu_pkg::N_IN-1:0][7:0]          ddc_data_o,
   output logic [edid_emu_pkg::N_IN-1:0]               sink_presence_line_o,
   output logic [edid_emu_pkg::N_IN-1:0]               hdmi_capable_o,
   input  wire logic [edid_emu_pkg::N_IN-1:0]          hdcp_en_i,
   output logic [edid_emu_pkg::N_IN-1:0]               hdcp_capable_o,
   input  wire logic [edid_emu_pkg::N_IN-1:0]          stream_enc_i,
   input  wire logic [edid_emu_pkg::IN_W-1:0]          route_i,
   input  wire logic                                   out_auto_i,
   input  wire logic                                   sink_hdcp_i,
   output logic                                        out_encrypt_o,
   output logic                                        alert_screen_o,
   input  wire logic [edid_emu_pkg::N_LANES-1:0]       lane_p_i,
   input  wire logic [edid_emu_pkg::N_LANES-1:0]       lane_n_i,
   input  wire logic [edid_emu_pkg::N_LANES-1:0]       lane_mark_i,
   output logic [edid_emu_pkg::N_LANES-1:0]            lane_o
);
   import edid_emu_pkg::*;

   // whole module state; one struct, one register
   typedef struct packed {
      logic [N_IN-1:0][255:0][7:0]        emu;      // per-input memory
      emu_mode_t [N_IN-1:0]               mode;     // emulation mode
      logic [N_IN-1:0]                    dyn_req;  // pending refresh
      logic [N_IN-1:0]                    ext;      // extension present
      logic [N_IN-1:0]                    hdmi;     // HDMI tag found
      logic [23:0]                        tag_sh;   // last three bytes
      logic [N_IN-1:0][HPD_W-1:0]         hpd_cnt;  // presence timer
      logic [N_IN-1:0]                    pres;     // presence line
      logic [N_IN-1:0][7:0]               ddc;      // read answers
      logic [N_IN-1:0]                    cap;      // reported capability
      copy_state_t                        cst;      // copy engine state
      logic                               ready;    // idle, a command can be taken
      logic [IN_W-1:0]                    cin;      // input being copied
      logic [8:0]                         rd_addr;  // next byte to fetch
      logic                               wr_pend;  // fetched byte due
      logic [7:0]                         wr_addr;  // address of due byte
      logic [7:0]                         fetch_addr; // address being fetched
      logic                               src_rd;   // fetch strobe
      logic                               src_dyn;  // fetch from store
      logic [ENTRY_W-1:0]                 src_ent;  // library entry
      logic                               nvm_we;   // store strobe
      logic [7:0]                         nvm_addr; // store address
      logic [7:0]                         nvm_data; // store data
      logic [1:0]                         cap_s;    // sink capability sync
      logic [1:0][N_LANES-1:0]            p_s;      // lane p sync
      logic [1:0][N_LANES-1:0]            n_s;      // lane n sync
      logic [1:0][N_LANES-1:0]            m_s;      // marker sync
      logic [N_LANES-1:0]                 bit_q;    // resolved lane bit
      logic [N_LANES-1:0][SKEW_DEPTH-1:0] dl;       // delay lines
      logic [N_LANES-1:0][2:0]            age;      // cycles since marker
      logic [N_LANES-1:0][1:0]            tap;      // chosen delay
      logic [N_LANES-1:0]                 lane;     // aligned lane out
      logic                               enc;      // output encryption
      logic                               alert;    // alert screen
   } st_t;

   st_t st_reg;   // registered state
   st_t st_next;  // next state

   // the load cycle is already the first low cycle, so load one less
   localparam logic [HPD_W-1:0] HPD_LOAD = HPD_W'(HPD_CYC - 1);

   // next-state logic for every part of the block
   always_comb begin
      logic       all_fresh;
      logic       any_new;
      logic       start;
      logic       done;
      logic       pick;
      all_fresh = 1'b1;
      any_new   = 1'b0;
      start     = 1'b0;
      done      = 1'b0;
      pick      = 1'b0;
      st_next   = st_reg;

      // byte reads from the source side, answered a cycle later
      for (int i = 0; i < N_IN; i++) begin
         if (ddc_rd_i[i]) begin
            if (ddc_addr_i[i] > BASE_LAST && !st_reg.ext[i]) begin
               st_next.ddc[i] = NO_DATA;
            end else begin
               st_next.ddc[i] = st_reg.emu[i][ddc_addr_i[i]];
            end
         end
         // protection capability reported straight from the enable
         st_next.cap[i] = hdcp_en_i[i];
         // presence line held low while the timer runs
         if (st_reg.hpd_cnt[i] != '0) begin
            st_next.hpd_cnt[i] = st_reg.hpd_cnt[i] - 1'b1;
            st_next.pres[i]    = 1'b0;
         end else begin
            st_next.pres[i]    = 1'b1;
         end
         // new sink structure stored: queue refresh, set beats clear unless a command starts the copy
         if (sink_new_i && st_reg.mode[i] == MODE_DYNAMIC) begin
            st_next.dyn_req[i] = 1'b1;
         end
      end

      // sink structure bytes go on to the non-volatile store
      st_next.nvm_we   = sink_wr_i;
      st_next.nvm_addr = sink_addr_i;
      st_next.nvm_data = sink_data_i;

      // copy engine
      st_next.src_rd = 1'b0;
      case (st_reg.cst)
         C_IDLE: begin
            if (cmd_valid_i) begin
               // any entry may go to any input
               start           = 1'b1;
               pick            = cmd_input_i;
               st_next.mode[cmd_input_i] = cmd_dynamic_i ? MODE_DYNAMIC
                                                         : MODE_STATIC;
               st_next.src_dyn = cmd_dynamic_i;
               st_next.src_ent = cmd_entry_i;
            end else if (st_reg.dyn_req != '0) begin
               start           = 1'b1;
               pick            = st_reg.dyn_req[0] ? 1'b0 : 1'b1;
               st_next.src_dyn = 1'b1;
            end
            if (start) begin
               // source stays attached; no disconnect needed
               st_next.cst          = C_COPY;
               st_next.cin          = pick;
               st_next.dyn_req[pick] = sink_new_i
                                     && st_reg.mode[pick] == MODE_DYNAMIC
                                     && !cmd_valid_i;
               st_next.ext[pick]    = 1'b0;
               st_next.hdmi[pick]   = 1'b0;
               st_next.rd_addr      = '0;
               st_next.wr_pend      = 1'b0;
               st_next.tag_sh       = '0;
            end
         end
         C_COPY: begin
            // fetch runs one byte ahead of the write; the read is synchronous,
            // so the write stage replays last cycle's strobe and address
            st_next.src_rd     = !st_reg.rd_addr[8];
            st_next.fetch_addr = st_reg.rd_addr[7:0];
            st_next.wr_pend    = st_reg.src_rd;
            st_next.wr_addr    = st_reg.fetch_addr;
            if (!st_reg.rd_addr[8]) begin
               st_next.rd_addr = st_reg.rd_addr + 9'h001;
            end
            if (st_reg.wr_pend) begin
               // only the chosen input's memory is touched
               st_next.emu[st_reg.cin][st_reg.wr_addr] = src_data_i;
               if (st_reg.wr_addr == EXT_CNT_ADDR) begin
                  st_next.ext[st_reg.cin] = src_data_i != 8'h00;
               end
               st_next.tag_sh = {st_reg.tag_sh[15:0], src_data_i};
               // tag counts only inside a present extension
               if (st_reg.wr_addr > BASE_LAST && st_reg.ext[st_reg.cin]
                   && st_next.tag_sh == HDMI_TAG) begin
                  st_next.hdmi[st_reg.cin] = 1'b1;
               end
               done = (st_reg.wr_addr == BASE_LAST && !st_reg.ext[st_reg.cin])
                    || st_reg.wr_addr == FULL_LAST;
            end
            if (done) begin
               st_next.cst     = C_IDLE;
               st_next.src_rd  = 1'b0;
               st_next.wr_pend = 1'b0;
               st_next.hpd_cnt[st_reg.cin] = HPD_LOAD;
               st_next.pres[st_reg.cin]    = 1'b0;
            end
         end
         default: begin
            st_next.cst = C_IDLE;
         end
      endcase
      st_next.ready = (st_next.cst == C_IDLE) && !start;

      // output protection: never encrypt to a non-capable sink
      st_next.cap_s = {st_reg.cap_s[0], sink_hdcp_i};
      st_next.enc   = st_reg.cap_s[1]
                    && (out_auto_i ? stream_enc_i[route_i] : 1'b1);
      st_next.alert = stream_enc_i[route_i] && !st_reg.cap_s[1];

      // lane pins: sync, settle pair skew, then align lanes
      st_next.p_s = {st_reg.p_s[0], lane_p_i};
      st_next.n_s = {st_reg.n_s[0], lane_n_i};
      st_next.m_s = {st_reg.m_s[0], lane_mark_i};
      for (int l = 0; l < N_LANES; l++) begin
         // equal wires mean mid-transition; keep last bit
         if (st_reg.p_s[1][l] != st_reg.n_s[1][l]) begin
            st_next.bit_q[l] = st_reg.p_s[1][l];
         end
         st_next.dl[l] = {st_reg.dl[l][SKEW_DEPTH-2:0], st_reg.bit_q[l]};
         if (st_reg.m_s[1][l]) begin
            st_next.age[l] = '0;
            any_new        = 1'b1;
         end else if (st_reg.age[l] != 3'(SKEW_DEPTH)) begin
            st_next.age[l] = st_reg.age[l] + 3'h1;
         end
         all_fresh = all_fresh && st_next.age[l] != 3'(SKEW_DEPTH);
      end
      for (int l = 0; l < N_LANES; l++) begin
         // latest lane gets no delay, earlier lanes wait for it
         if (any_new && all_fresh) begin
            st_next.tap[l] = st_next.age[l][1:0];
         end
         st_next.lane[l] = st_reg.dl[l][st_reg.tap[l]];
      end
   end

   // single state register, synchronous reset
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         st_reg      <= '0;
         st_reg.pres <= '1;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from the state register
   assign cmd_ready_o          = st_reg.ready;
   assign src_rd_o             = st_reg.src_rd;
   assign src_dynamic_o        = st_reg.src_dyn;
   assign src_entry_o          = st_reg.src_ent;
   assign src_addr_o           = st_reg.fetch_addr;
   assign nvm_we_o             = st_reg.nvm_we;
   assign nvm_addr_o           = st_reg.nvm_addr;
   assign nvm_data_o           = st_reg.nvm_data;
   assign ddc_data_o           = st_reg.ddc;
   assign sink_presence_line_o = st_reg.pres;
   assign hdmi_capable_o       = st_reg.hdmi;
   assign hdcp_capable_o       = st_reg.cap;
   assign out_encrypt_o        = st_reg.enc;
   assign alert_screen_o       = st_reg.alert;
   assign lane_o               = st_reg.lane;

   // helper: memory of the input not being copied is unchanged
   logic other_same;
   assign other_same = st_next.emu[~st_reg.cin] == st_reg.emu[~st_reg.cin];

   a_copy_isolation: assert property (@(posedge clk_i) disable iff (reset_i)
      st_reg.cst == C_COPY |-> other_same)
      else $error("copy touched another input");
   a_presence_drop: assert property (@(posedge clk_i) disable iff (reset_i)
      st_reg.cst == C_COPY && st_next.cst == C_IDLE
      |=> !sink_presence_line_o[$past(st_reg.cin)] ##1 !sink_presence_line_o[$past(st_reg.cin, 2)])
      else $error("presence line not dropped after change");
   a_base_length: assert property (@(posedge clk_i) disable iff (reset_i)
      st_reg.cst == C_COPY && st_next.cst == C_IDLE && !st_reg.ext[st_reg.cin]
      |-> st_reg.wr_addr == BASE_LAST)
      else $error("base copy length wrong");
   a_hdmi_needs_ext: assert property (@(posedge clk_i) disable iff (reset_i)
      (hdmi_capable_o & ~st_reg.ext) == '0)
      else $error("HDMI flagged without extension");
   a_no_enc_plain: assert property (@(posedge clk_i) disable iff (reset_i)
      out_encrypt_o |-> $past(st_reg.cap_s[1]))
      else $error("encrypted stream to non-capable sink");
   a_alert_shown: assert property (@(posedge clk_i) disable iff (reset_i)
      stream_enc_i[route_i] && !st_reg.cap_s[1] |=> alert_screen_o)
      else $error("alert screen missing");
   a_cap_report: assert property (@(posedge clk_i) disable iff (reset_i)
      ##1 hdcp_capable_o == $past(hdcp_en_i))
      else $error("reported capability differs from enable");
   a_auto_clear: assert property (@(posedge clk_i) disable iff (reset_i)
      out_auto_i && !stream_enc_i[route_i] |=> !out_encrypt_o)
      else $error("unprotected content encrypted in auto mode");
   a_store_sink: assert property (@(posedge clk_i) disable iff (reset_i)
      sink_wr_i |=> nvm_we_o && nvm_addr_o == $past(sink_addr_i)
                 && nvm_data_o == $past(sink_data_i))
      else $error("sink byte not stored");
   a_dyn_follow: assert property (@(posedge clk_i) disable iff (reset_i)
      sink_new_i && st_reg.mode[0] == MODE_DYNAMIC
      |=> st_reg.dyn_req[0] || (st_reg.cst == C_COPY && st_reg.cin == 1'b0))
      else $error("dynamic input ignored new sink");
   a_ddc_answer: assert property (@(posedge clk_i) disable iff (reset_i)
      ddc_rd_i[0] && ddc_addr_i[0] <= BASE_LAST
      |=> ddc_data_o[0] == $past(st_reg.emu[0][ddc_addr_i[0]]))
      else $error("read answer wrong");
endmodule

// ===== test/edid_src_model.sv
// library and sink-store memory model answering the fetch port
`timescale 1ns/10ps
package edid_lib_pkg;
   // byte a of pattern e: e[0] adds the extension, e[1] with it the hdmi tag
   function automatic logic [7:0] lib_byte(input logic [5:0] e, input logic [7:0] a);
      if (a == 8'h7E) return {7'h00, e[0]};
      if (e[1:0] == 2'b11 && a == 8'h84) return 8'h03;
      if (e[1:0] == 2'b11 && a == 8'h85) return 8'h0C;
      if (e[1:0] == 2'b11 && a == 8'h86) return 8'h00;
      return a ^ {e, 2'b01};                              // cannot mimic the tag
   endfunction
endpackage

module edid_src_model
   import edid_lib_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       src_rd_i,
   input  wire logic       src_dyn_i,
   input  wire logic [5:0] src_entry_i,
   input  wire logic [7:0] src_addr_i,
   input  wire logic       nvm_we_i,
   input  wire logic [7:0] nvm_addr_i,
   input  wire logic [7:0] nvm_data_i,
   output logic      [7:0] src_data_o
);
   logic [7:0] store_mem [256];  // sink store, kept after the sink goes away
   logic [7:0] val;              // byte addressed this cycle

   // dynamic fetches come from the store, static ones from the library
   always_comb val = src_dyn_i ? store_mem[src_addr_i] : lib_byte(src_entry_i, src_addr_i);

   // one-cycle read; without a fetch the bus shows junk, not a stale byte
   always @(posedge clk_i) begin
      if (nvm_we_i) store_mem[nvm_addr_i] <= nvm_data_i;
      src_data_o <= src_rd_i ? val : ~val;
   end
endmodule

// ===== test/tb.sv
// self-checking bench for the identification emulator
`timescale 1ns/10ps
module tb;
   import edid_emu_pkg::*;
   import edid_lib_pkg::*;
   localparam int HPD = 20;  // short presence-low time keeps the run brief
   logic clk_i = 1'b0, reset_i = 1'b1, cmd_valid_i = 1'b0, cmd_input_i = 1'b0;
   logic cmd_dynamic_i = 1'b0, sink_wr_i = 1'b0, sink_new_i = 1'b0;
   logic route_i = 1'b0, out_auto_i = 1'b0, sink_hdcp_i = 1'b0;
   logic [5:0] cmd_entry_i = 6'h00;
   logic [7:0] sink_addr_i = 8'h00, sink_data_i = 8'h00;
   logic [1:0] ddc_rd_i = 2'b00, hdcp_en_i = 2'b00, stream_enc_i = 2'b00;
   logic [1:0][7:0] ddc_addr_i = '0;
   logic [8:0] lh = 9'h000;  // lane bit history; lane l shows lh[l], its n wire a cycle later
   logic [3:0] mh = 4'h0;    // marker history, skewed like the data
   logic ph = 1'b0, mk_go = 1'b0;  // two-cycle bit phase, marker request
   logic [2:0] lane_o;
   logic cmd_ready_o, src_rd_o, src_dynamic_o, nvm_we_o, out_encrypt_o, alert_screen_o;
   logic [5:0] src_entry_o;
   logic [7:0] src_addr_o, src_data_i, nvm_addr_o, nvm_data_o;
   logic [1:0][7:0] ddc_data_o;
   logic [1:0] sink_presence_line_o, hdmi_capable_o, hdcp_capable_o, rd_seen = 2'b00;
   logic [7:0] ddc_q [$];   // expected ddc answers
   logic [15:0] nvm_q [$];  // expected store writes, address and data
   int miscompares = 0, total_checks = 0;
   logic [31:0] r;
   logic [5:0] e0, e1;

   edid_emu_hdcp #(.HPD_CYC(HPD)) i_edid_emu_hdcp (.clk_i(clk_i), .reset_i(reset_i),
      .cmd_valid_i(cmd_valid_i), .cmd_input_i(cmd_input_i), .cmd_dynamic_i(cmd_dynamic_i),
      .cmd_entry_i(cmd_entry_i), .cmd_ready_o(cmd_ready_o), .src_rd_o(src_rd_o),
      .src_dynamic_o(src_dynamic_o), .src_entry_o(src_entry_o), .src_addr_o(src_addr_o),
      .src_data_i(src_data_i), .sink_wr_i(sink_wr_i), .sink_addr_i(sink_addr_i),
      .sink_data_i(sink_data_i), .sink_new_i(sink_new_i), .nvm_we_o(nvm_we_o),
      .nvm_addr_o(nvm_addr_o), .nvm_data_o(nvm_data_o), .ddc_rd_i(ddc_rd_i),
      .ddc_addr_i(ddc_addr_i), .ddc_data_o(ddc_data_o),
      .sink_presence_line_o(sink_presence_line_o), .hdmi_capable_o(hdmi_capable_o),
      .hdcp_en_i(hdcp_en_i), .hdcp_capable_o(hdcp_capable_o), .stream_enc_i(stream_enc_i),
      .route_i(route_i), .out_auto_i(out_auto_i), .sink_hdcp_i(sink_hdcp_i),
      .out_encrypt_o(out_encrypt_o), .alert_screen_o(alert_screen_o), .lane_p_i(lh[2:0]),
      .lane_n_i(~lh[3:1]), .lane_mark_i(mh[2:0]), .lane_o(lane_o));
   edid_src_model i_edid_src_model (.clk_i(clk_i), .src_rd_i(src_rd_o),
      .src_dyn_i(src_dynamic_o), .src_entry_i(src_entry_o), .src_addr_i(src_addr_o),
      .nvm_we_i(nvm_we_o), .nvm_addr_i(nvm_addr_o), .nvm_data_i(nvm_data_o),
      .src_data_o(src_data_i));

   always #5 clk_i = ~clk_i;

   // skewed lanes: lane l lags l cycles, each bit lasts two cycles so the
   // one-cycle n lag stays inside a bit
   always @(posedge clk_i) begin
      ph <= ~ph;
      lh <= {lh[7:0], ph ? 1'($urandom) : lh[0]};
      mh <= {mh[2:0], mk_go};
   end

   // single compare for every kind of result, zero-extended to 16 bits
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic close_out();
      if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // one negedge of a bounded wait; an exhausted bound ends the run
   task automatic step(inout int n);
      @(negedge clk_i);
      n++;
      if (n > 700) begin
         miscompares++;
         $display("[ERR] %0t wait bound used up", $time);
         close_out();
      end
   endtask
   // presence must fall after the copy and stay low exactly HPD cycles
   task automatic presence(input int k);
      int n = 0;
      while (sink_presence_line_o[k] !== 1'b0) step(n);
      n = 0;
      while (sink_presence_line_o[k] === 1'b0) step(n);
      chk(16'(n), 16'(HPD), "presence low time");
      @(posedge clk_i);
   endtask
   // one command, taken only while ready is shown
   task automatic set_input(input logic k, input logic dyn, input logic [5:0] e);
      int n = 0;
      while (cmd_ready_o !== 1'b1) step(n);
      @(posedge clk_i);
      cmd_valid_i <= 1'b1;
      cmd_input_i <= k;
      cmd_dynamic_i <= dyn;
      cmd_entry_i <= e;
      @(posedge clk_i);
      cmd_valid_i <= 1'b0;
      cmd_entry_i <= ~e;  // entry scrambled once released
      presence(k);
   endtask
   // one ddc byte read; the monitor compares the answer
   task automatic ddc(input int k, input logic [7:0] a, input logic [7:0] e);
      ddc_rd_i[k] <= 1'b1;
      ddc_addr_i[k] <= a;
      ddc_q.push_back(e);
      @(posedge clk_i);
      ddc_rd_i[k] <= 1'b0;
      ddc_addr_i[k] <= ~a;
      @(posedge clk_i);
   endtask
   // read bytes 0..last of input k, expecting pattern e; no extension reads as empty
   task automatic read_all(input int k, input logic [5:0] e, input int last);
      for (int a = 0; a <= last; a++)
         ddc(k, a[7:0], (a > 127 && !e[0]) ? NO_DATA : lib_byte(e, a[7:0]));
   endtask
   // sink hands over a whole structure, then flags it complete
   task automatic sink_load(input logic [5:0] e);
      for (int a = 0; a < 256; a++) begin
         sink_wr_i <= 1'b1;
         sink_addr_i <= a[7:0];
         sink_data_i <= lib_byte(e, a[7:0]);
         nvm_q.push_back({a[7:0], lib_byte(e, a[7:0])});
         @(posedge clk_i);
      end
      sink_wr_i <= 1'b0;
      sink_new_i <= 1'b1;
      @(posedge clk_i);
      sink_new_i <= 1'b0;
   endtask

   // answers land on the edge that takes the read, so look half a cycle later
   always @(posedge clk_i) rd_seen <= ddc_rd_i;
   always @(negedge clk_i) begin
      for (int k = 0; k < 2; k++)
         if (rd_seen[k]) chk(16'(ddc_data_o[k]), 16'(ddc_q.pop_front()), "ddc");
      if (nvm_we_o === 1'b1) chk({nvm_addr_o, nvm_data_o}, nvm_q.pop_front(), "nvm");
   end

   initial begin
      repeat (100000) @(posedge clk_i);
      miscompares++;
      $display("[ERR] %0t run too long", $time);
      close_out();
   end

   initial begin
      r = $urandom(36271);
      r = $urandom;
      e0 = {r[3:0], 2'b00};
      e1 = {r[7:4], 2'b11};
      repeat (20) @(posedge clk_i);
      reset_i <= 1'b0;
      @(negedge clk_i);
      chk(16'(sink_presence_line_o), 16'h0003, "presence after reset");
      @(posedge clk_i);
      ddc(1, 8'h05, 8'h00);
      set_input(1'b0, 1'b0, e0);
      read_all(0, e0, 129);
      ddc(1, 8'h05, 8'h00);
      chk(16'(hdmi_capable_o), 16'h0000, "hdmi base only");
      set_input(1'b1, 1'b0, e1);
      read_all(1, e1, 255);
      chk(16'(hdmi_capable_o), 16'h0002, "hdmi tagged");
      ddc(0, {1'b0, r[14:8]}, lib_byte(e0, {1'b0, r[14:8]}));
      set_input(1'b1, 1'b0, {r[11:8], 2'b01});
      chk(16'(hdmi_capable_o), 16'h0000, "extension alone");
      sink_load(6'h2F);
      set_input(1'b1, 1'b1, 6'h00);
      read_all(1, 6'h2F, 255);
      chk(16'(hdmi_capable_o), 16'h0002, "hdmi from sink");
      sink_load(6'h30);
      presence(1);
      read_all(1, 6'h30, 129);
      read_all(0, e0, 3);
      for (int i = 0; i < 128; i++) begin
         r = $urandom;
         {hdcp_en_i, stream_enc_i, route_i, out_auto_i, sink_hdcp_i} <= i[6:0] ^ r[6:0];
         repeat (5) @(posedge clk_i);
         @(negedge clk_i);
         chk(16'(hdcp_capable_o), 16'(hdcp_en_i), "capability");
         chk(16'(out_encrypt_o), 16'(sink_hdcp_i & (!out_auto_i | stream_enc_i[route_i])),
             "encrypt");
         chk(16'(alert_screen_o), 16'(stream_enc_i[route_i] & !sink_hdcp_i), "alert");
         @(posedge clk_i);
      end
      // one marker per lane, then every lane must carry the same bit,
      // eight edges after it entered the history (sync, pair hold, delay, register)
      mk_go <= 1'b1;
      @(posedge clk_i);
      mk_go <= 1'b0;
      repeat (16) @(posedge clk_i);
      for (int i = 0; i < 64; i++) begin
         @(negedge clk_i);
         chk(16'(lane_o), 16'({3{lh[8]}}), "lanes aligned");
      end
      close_out();
   end
endmodule
